// >>> hdl/dcd_top.sv
/*
  ds0 channel drop and datalink port: channel select, data bit display,
  level meter, serial drop and esf datalink insert, apb registers and irq.
  assumes an upstream t1 framer on pclk giving bit strobes with timeslot,
  bit index and frame number, and taking inserted datalink bits.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dcd_defines.svh"
module dcd_top #(
  parameter int unsigned CLIP_HOLD_CYC = `DCD_CLIP_HOLD_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // upstream framer
  input wire logic fr_sync_lost,
  input wire logic fr_bit_stb,
  input wire logic fr_bit,
  input wire logic [4:0] fr_ts,
  input wire logic [2:0] fr_bit_idx,
  input wire logic [4:0] fr_frame,
  input wire logic fr_dl_req,
  output logic dl_ins_bit,
  output logic dl_ins_stb,
  // serial port pins
  output logic ser_tx_clk,
  output logic ser_tx_data,
  output logic ser_rx_clk,
  input wire logic ser_rx_data,
  // front panel
  output logic [7:0] data_leds,
  output logic sync_loss_led,
  output dcd_pkg::dcd_fmt_type fmt_leds,
  output logic [3:0] chan_tens,
  output logic [3:0] chan_ones,
  output logic [19:0] level_bar,
  output logic clip_led,
  // interrupt
  output logic irq
);
  import dcd_pkg::*;

  dcd_top_type q, d;
  logic [4:0] lit;
  logic clip_evt;
  logic ins_bit;
  logic ins_stb;
  logic ins_req;
  logic [2:0] ev;
  logic [2:0] clr;
  logic acc_wr;
  logic in_chan;
  logic dl_slot;
  logic [31:0] rd;
  logic hit;

  function automatic logic [4:0] chan_of(dcd_fmt_type f,
                                         logic [4:0] ts);
    logic [6:0] base;
    base = 7'(ts - 5'h01) * 7'h05;
    case (f)
      fmt_d1d, fmt_loop_carrier: begin
        if (ts[0]) begin
          chan_of = 5'((ts + 5'h01) >> 1);
        end else begin
          chan_of = 5'h0C + (ts >> 1);
        end
      end
      fmt_d2: chan_of = dcd_d2_tab[base +: 5];
      default: chan_of = ts;
    endcase
  endfunction : chan_of

  dcd_level_meter #(
    .CLIP_HOLD_CYC(CLIP_HOLD_CYC)
  ) u_meter (
    .pclk(pclk),
    .presetn(presetn),
    .smp(q.last_byte),
    .smp_stb(q.smp_stb),
    .bar(level_bar),
    .lit(lit),
    .clip_led(clip_led),
    .clip_evt(clip_evt)
  );

  dcd_serial_port u_ser (
    .pclk(pclk),
    .presetn(presetn),
    .drop_bit(q.drop_bit),
    .drop_stb(q.drop_stb),
    .ins_req(ins_req),
    .ins_bit(ins_bit),
    .ins_stb(ins_stb),
    .ser_tx_clk(ser_tx_clk),
    .ser_tx_data(ser_tx_data),
    .ser_rx_clk(ser_rx_clk),
    .ser_rx_data(ser_rx_data)
  );

  // insertion follows the format only, never source or channel
  assign ins_req = fr_dl_req && (q.fmt == fmt_esf);

  always_comb begin
    d = q;
    ev = 3'h0;
    clr = 3'h0;
    rd = 32'h00000000;
    hit = 1'b1;
    in_chan = 1'b0;
    dl_slot = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.smp_stb = 1'b0;
    d.drop_stb = 1'b0;
    d.dl_stb = 1'b0;
    acc_wr = psel && penable && q.pready && pwrite && !q.pslverr;

    // read decode in the setup cycle so data leaves a flop
    case (paddr)
      `DCD_CTRL_OFS: begin
        rd[`DCD_CTRL_FMT_LSB +: 5] = q.fmt;
        rd[`DCD_CTRL_CHAN_LSB +: 5] = q.chan;
        rd[`DCD_CTRL_SRC_BIT] = q.src_chan;
      end
      `DCD_STAT_OFS: begin
        rd[`DCD_STAT_SYNC_BIT] = q.sync_lost;
        rd[`DCD_STAT_BYTE_LSB +: 8] = q.last_byte;
        rd[`DCD_STAT_LIT_LSB +: 5] = lit;
        rd[`DCD_STAT_CLIP_BIT] = clip_led;
      end
      `DCD_INT_STAT_OFS: rd[2:0] = q.ist;
      `DCD_INT_CLR_OFS: rd = 32'h00000000;
      `DCD_INT_EN_OFS: rd[2:0] = q.ien;
      default: hit = 1'b0;
    endcase
    if (psel && !penable) begin
      d.pready = 1'b1;
      d.pslverr = !hit;
      d.prdata = pwrite ? 32'h00000000 : rd;
    end

    // register writes at the access edge
    if (acc_wr) begin
      case (paddr)
        `DCD_CTRL_OFS: begin
          // an illegal format or channel code keeps the old setting
          if ($onehot(pwdata[`DCD_CTRL_FMT_LSB +: 5])) begin
            d.fmt = dcd_fmt_type'(pwdata[`DCD_CTRL_FMT_LSB +: 5]);
          end
          if (pwdata[`DCD_CTRL_CHAN_LSB +: 5] != 5'h00 &&
              pwdata[`DCD_CTRL_CHAN_LSB +: 5] <= `DCD_CHAN_MAX) begin
            d.chan = pwdata[`DCD_CTRL_CHAN_LSB +: 5];
          end
          d.src_chan = pwdata[`DCD_CTRL_SRC_BIT];
        end
        `DCD_INT_CLR_OFS: clr = pwdata[2:0];
        `DCD_INT_EN_OFS: d.ien = pwdata[2:0];
        default: d.ien = q.ien;
      endcase
    end

    // two-digit channel readout
    if (d.chan >= 5'h14) begin
      d.tens = 4'h2;
      d.ones = 4'(d.chan - 5'h14);
    end else if (d.chan >= 5'h0A) begin
      d.tens = 4'h1;
      d.ones = 4'(d.chan - 5'h0A);
    end else begin
      d.tens = 4'h0;
      d.ones = 4'(d.chan);
    end

    // frame position from the framer locates channel and datalink
    d.sync_lost = fr_sync_lost;
    ev[`DCD_EV_SYNC] = fr_sync_lost && !q.sync_lost;
    if (fr_bit_stb && !fr_sync_lost) begin
      if (fr_ts == 5'h00) begin
        // esf datalink rides odd frames, loop carrier on even ones
        dl_slot = ((q.fmt == fmt_esf) && fr_frame[0]) ||
                  ((q.fmt == fmt_loop_carrier) && !fr_frame[0]);
        if (dl_slot && !q.src_chan) begin
          d.drop_bit = fr_bit;
          d.drop_stb = 1'b1;
        end
      end else begin
        in_chan = (chan_of(q.fmt, fr_ts) == q.chan);
      end
    end
    if (in_chan) begin
      d.shift = {q.shift[6:0], fr_bit};
      if (q.src_chan) begin
        d.drop_bit = fr_bit;
        d.drop_stb = 1'b1;
      end
      if (fr_bit_idx == 3'h7) begin
        d.last_byte = {q.shift[6:0], fr_bit};
        d.leds = {q.shift[6:0], fr_bit};
        d.smp_stb = 1'b1;
      end
    end
    if (fr_sync_lost) begin
      d.leds = 8'h00;
    end

    // sampled insert bits go to the framer only under esf
    if (ins_stb && (q.fmt == fmt_esf)) begin
      d.dl_bit = ins_bit;
      d.dl_stb = 1'b1;
      ev[`DCD_EV_INS] = 1'b1;
    end

    // a clear in the same cycle as a new event loses to the event
    ev[`DCD_EV_CLIP] = clip_evt;
    d.ist = (q.ist & ~clr) | ev;
    d.irq = |(d.ist & d.ien);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{fmt: fmt_d3d4, chan: `DCD_CHAN_RST, tens: 4'h2,
             ones: 4'h4, default: '0};
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign dl_ins_bit = q.dl_bit;
  assign dl_ins_stb = q.dl_stb;
  assign data_leds = q.leds;
  assign sync_loss_led = q.sync_lost;
  assign fmt_leds = q.fmt;
  assign chan_tens = q.tens;
  assign chan_ones = q.ones;
  assign irq = q.irq;
endmodule : dcd_top
`default_nettype wire

// >>> common/dcd_defines.svh
/*
  register map, field positions, reset values and timing counts of the
  ds0 channel drop block. assumes a 32-bit apb with 12-bit byte address.
*/
`ifndef DCD_DEFINES_SVH
`define DCD_DEFINES_SVH
`define DCD_ADDR_W 12
`define DCD_CTRL_OFS 12'h000
`define DCD_STAT_OFS 12'h004
`define DCD_INT_STAT_OFS 12'h008
`define DCD_INT_CLR_OFS 12'h00C
`define DCD_INT_EN_OFS 12'h010
`define DCD_CTRL_FMT_LSB 0
`define DCD_CTRL_CHAN_LSB 8
`define DCD_CTRL_SRC_BIT 16
`define DCD_STAT_SYNC_BIT 0
`define DCD_STAT_BYTE_LSB 8
`define DCD_STAT_LIT_LSB 16
`define DCD_STAT_CLIP_BIT 24
`define DCD_CHAN_RST 5'h18
`define DCD_CHAN_MAX 5'h18
`define DCD_EV_SYNC 0
`define DCD_EV_CLIP 1
`define DCD_EV_INS 2
`define DCD_CLK_PERIOD_NS 40
`define DCD_CLK_MHZ 25
`define DCD_LINK_PERIOD_NS 320
`define DCD_LINK_HALF_CYC ((`DCD_LINK_PERIOD_NS / `DCD_CLK_PERIOD_NS) / 2)
`define DCD_CLIP_HOLD_MS 100
`define DCD_CLIP_HOLD_CYC (`DCD_CLIP_HOLD_MS * 1000 * `DCD_CLK_MHZ)
`define DCD_BAR_SEGS 20
`define DCD_BAR_OFFSET 5'h04
`endif

// >>> common/dcd_pkg.sv
/*
  types of the ds0 channel drop block: framing formats, serial phases and
  the packed state of each module. assumes dcd_defines.svh alongside.
*/
package dcd_pkg;
  typedef enum logic [4:0] {
    fmt_esf = 5'h01,
    fmt_loop_carrier = 5'h02,
    fmt_d3d4 = 5'h04,
    fmt_d2 = 5'h08,
    fmt_d1d = 5'h10
  } dcd_fmt_type;

  typedef enum logic [2:0] {
    ph_idle = 3'h1,
    ph_low = 3'h2,
    ph_high = 3'h4
  } dcd_phase_type;

  // d2 channel of timeslot n sits at bits (n-1)*5
  localparam logic [119:0] dcd_d2_tab = {5'h18, 5'h08, 5'h14, 5'h04,
    5'h10, 5'h0A, 5'h16, 5'h06, 5'h12, 5'h02, 5'h0E, 5'h0B, 5'h17,
    5'h07, 5'h13, 5'h03, 5'h0F, 5'h09, 5'h15, 5'h05, 5'h11, 5'h01,
    5'h0D, 5'h0C};

  typedef struct packed {
    dcd_fmt_type fmt;
    logic [4:0] chan;
    logic src_chan;
    logic [7:0] shift;
    logic [7:0] leds;
    logic [7:0] last_byte;
    logic smp_stb;
    logic sync_lost;
    logic [3:0] tens;
    logic [3:0] ones;
    logic drop_bit;
    logic drop_stb;
    logic dl_bit;
    logic dl_stb;
    logic [2:0] ist;
    logic [2:0] ien;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dcd_top_type;

  typedef struct packed {
    dcd_phase_type tx_ph;
    logic [2:0] tx_cnt;
    logic tx_clk;
    logic tx_data;
    dcd_phase_type rx_ph;
    logic [2:0] rx_cnt;
    logic rx_clk;
    logic rx_s1;
    logic rx_s2;
    logic ins_bit;
    logic ins_stb;
  } dcd_ser_type;

  typedef struct packed {
    logic [7:0] acc;
    logic [4:0] lit;
    logic [19:0] bar;
    logic [21:0] hold;
    logic clip_led;
    logic clip_evt;
  } dcd_meter_type;
endpackage : dcd_pkg

// >>> hdl/dcd_level_meter.sv
/*
  level bar graph and clipping indicator fed by mu-law samples of the
  selected channel. assumes one strobe per received channel byte.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dcd_defines.svh"
module dcd_level_meter #(
  parameter int unsigned CLIP_HOLD_CYC = `DCD_CLIP_HOLD_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // samples
  input wire logic [7:0] smp,
  input wire logic smp_stb,
  // indicators
  output logic [19:0] bar,
  output logic [4:0] lit,
  output logic clip_led,
  output logic clip_evt
);
  import dcd_pkg::*;
  dcd_meter_type q, d;
  logic [6:0] mag;
  logic [7:0] tgt;
  logic [8:0] diff;
  logic clip;

  always_comb begin
    d = q;
    d.clip_evt = 1'b0;
    // inverted code: 7F is the largest magnitude of either sign
    mag = ~smp[6:0];
    clip = smp_stb && (mag == 7'h7F);
    // 3 db steps: chord gives 6 db, top mantissa bit halves it
    tgt = {mag[6:3], 4'h0};
    diff = {1'b0, tgt} - {1'b0, q.acc};
    if (smp_stb) begin
      d.acc = q.acc + {{3{diff[8]}}, diff[7:3]};
    end
    if (q.acc[7:4] == 4'h0) begin
      d.lit = 5'h00;
    end else if (({1'b0, q.acc[7:4]} + `DCD_BAR_OFFSET) > 5'h13) begin
      d.lit = 5'h13;
    end else begin
      d.lit = {1'b0, q.acc[7:4]} + `DCD_BAR_OFFSET;
    end
    // hold keeps a single clipped sample visible to the eye
    if (clip) begin
      d.hold = 22'(CLIP_HOLD_CYC);
      d.clip_evt = 1'b1;
    end else if (q.hold != 22'h000000) begin
      d.hold = q.hold - 22'h000001;
    end
    d.clip_led = clip || (q.hold > 22'h000001);
    d.bar = ~(20'hFFFFF << d.lit);
    d.bar[19] = d.clip_led;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bar = q.bar;
  assign lit = q.lit;
  assign clip_led = q.clip_led;
  assign clip_evt = q.clip_evt;
endmodule : dcd_level_meter
`default_nettype wire

// >>> hdl/dcd_serial_port.sv
/*
  synchronous dce serial port: one gapped clock pulse per dropped bit out,
  one per requested insert bit in. assumes bits arrive slower than the
  link period; a strobe during a pulse is ignored.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dcd_defines.svh"
module dcd_serial_port (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // drop side
  input wire logic drop_bit,
  input wire logic drop_stb,
  // insert side
  input wire logic ins_req,
  output logic ins_bit,
  output logic ins_stb,
  // pins
  output logic ser_tx_clk,
  output logic ser_tx_data,
  output logic ser_rx_clk,
  input wire logic ser_rx_data
);
  import dcd_pkg::*;
  localparam logic [2:0] HALF = 3'(`DCD_LINK_HALF_CYC);
  dcd_ser_type q, d;

  always_comb begin
    d = q;
    d.ins_stb = 1'b0;
    d.rx_s1 = ser_rx_data;
    d.rx_s2 = q.rx_s1;
    unique case (q.tx_ph)
      ph_idle: if (drop_stb) begin
        d.tx_data = drop_bit;
        d.tx_clk = 1'b0;
        d.tx_cnt = HALF - 3'h1;
        d.tx_ph = ph_low;
      end
      ph_low: if (q.tx_cnt == 3'h0) begin
        d.tx_clk = 1'b1;
        d.tx_cnt = HALF - 3'h1;
        d.tx_ph = ph_high;
      end else begin
        d.tx_cnt = q.tx_cnt - 3'h1;
      end
      ph_high: if (q.tx_cnt == 3'h0) begin
        d.tx_ph = ph_idle;
      end else begin
        d.tx_cnt = q.tx_cnt - 3'h1;
      end
    endcase
    unique case (q.rx_ph)
      ph_idle: if (ins_req) begin
        d.rx_clk = 1'b0;
        d.rx_cnt = HALF - 3'h1;
        d.rx_ph = ph_low;
      end
      ph_low: if (q.rx_cnt == 3'h0) begin
        d.rx_clk = 1'b1;
        d.ins_bit = q.rx_s2;
        d.ins_stb = 1'b1;
        d.rx_cnt = HALF - 3'h1;
        d.rx_ph = ph_high;
      end else begin
        d.rx_cnt = q.rx_cnt - 3'h1;
      end
      ph_high: if (q.rx_cnt == 3'h0) begin
        d.rx_ph = ph_idle;
      end else begin
        d.rx_cnt = q.rx_cnt - 3'h1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{tx_ph: ph_idle, rx_ph: ph_idle, tx_clk: 1'b1,
             rx_clk: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign ins_bit = q.ins_bit;
  assign ins_stb = q.ins_stb;
  assign ser_tx_clk = q.tx_clk;
  assign ser_tx_data = q.tx_data;
  assign ser_rx_clk = q.rx_clk;
endmodule : dcd_serial_port
`default_nettype wire

// >>> testbench/dcd_monitor.sv
/*
  port assertions of dcd_top.
  assumes one pclk domain and an async active-low presetn.
*/
`timescale 1ns/100ps
`default_nettype none
module dcd_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // framer side
  input wire logic fr_sync_lost,
  input wire logic fr_bit_stb,
  input wire logic dl_ins_bit,
  input wire logic dl_ins_stb,
  // serial pins
  input wire logic ser_tx_clk,
  input wire logic ser_rx_clk,
  input wire logic ser_rx_data,
  // panel
  input wire logic [7:0] data_leds,
  input wire dcd_pkg::dcd_fmt_type fmt_leds,
  input wire logic [19:0] level_bar,
  input wire logic clip_led
);
  import dcd_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_tx_pulse;
    !ser_tx_clk[*4] ##1 ser_tx_clk[*4];
  endsequence
  sequence s_ins;
    !ser_rx_clk[*4] ##1 ser_rx_clk ##1 dl_ins_stb;
  endsequence
  property p_tx_pulse; $fell(ser_tx_clk) |-> s_tx_pulse; endproperty
  a_tx_pulse: assert property (p_tx_pulse)
    else $error("tx clock pulse wrong");
  // the drop strobe passes one register before the port starts its pulse
  property p_tx_cause;
    $fell(ser_tx_clk) |-> $past(fr_bit_stb, 2);
  endproperty
  a_tx_cause: assert property (p_tx_cause)
    else $error("tx pulse without bit");
  property p_ins; $fell(ser_rx_clk) |-> s_ins; endproperty
  a_ins: assert property (p_ins)
    else $error("insert cycle wrong");
  // insert only allowed while the esf format is shown
  property p_ins_fmt; $fell(ser_rx_clk) |-> $past(fmt_leds) == fmt_esf;
  endproperty
  a_ins_fmt: assert property (p_ins_fmt)
    else $error("insert outside esf");
  property p_ins_bit; dl_ins_stb |-> dl_ins_bit == $past(ser_rx_data, 4);
  endproperty
  a_ins_bit: assert property (p_ins_bit)
    else $error("insert bit wrong");
  property p_blank; fr_sync_lost |=> data_leds == 8'h00; endproperty
  a_blank: assert property (p_blank)
    else $error("leds not blank");
  property p_leds_cause;
    $changed(data_leds) |-> $past(fr_bit_stb) || $past(fr_sync_lost);
  endproperty
  a_leds_cause: assert property (p_leds_cause)
    else $error("leds changed alone");
  property p_clip; clip_led |-> level_bar[19]; endproperty
  a_clip: assert property (p_clip)
    else $error("clip without top segment");
  // lower segments form a bar with no gaps
  property p_bar;
    ((level_bar[18:0] + 19'h00001) & level_bar[18:0]) == 19'h00000;
  endproperty
  a_bar: assert property (p_bar)
    else $error("bar has a gap");
endmodule : dcd_monitor
bind dcd_top dcd_monitor i_dcd_monitor (.pclk, .presetn, .fr_sync_lost,
  .fr_bit_stb, .dl_ins_bit, .dl_ins_stb, .ser_tx_clk, .ser_rx_clk,
  .ser_rx_data, .data_leds, .fmt_leds, .level_bar, .clip_led);
`default_nettype wire

// >>> testbench/dcd_terminal.sv
/*
  terminal model on the serial port.
  assumes the block supplies both clocks as dce.
*/
`timescale 1ns/100ps
`default_nettype none
module dcd_terminal (
  // reset
  input wire logic presetn,
  // serial pins
  input wire logic ser_tx_clk,
  input wire logic ser_tx_data,
  input wire logic ser_rx_clk,
  output logic ser_rx_data,
  // observation
  output logic [7:0] tm_byte,
  output logic [7:0] tm_cnt,
  output logic sent
);
  logic [7:0] pat = 8'hB4;
  initial begin
    {tm_byte, tm_cnt, sent, ser_rx_data} = 18'h00001;
  end
  always @(posedge ser_tx_clk) if (presetn) begin
    tm_byte <= {tm_byte[6:0], ser_tx_data};
    tm_cnt <= tm_cnt + 8'h01;
  end
  // drive on the fall so data is settled well before the rise
  always @(negedge ser_rx_clk) if (presetn) begin
    ser_rx_data <= pat[7];
    sent <= pat[7];
    pat <= {pat[6:0], pat[7]};
  end
  // hold is over after the rise: show the inverse, not a stale bit
  always @(posedge ser_rx_clk) ser_rx_data <= ~sent;
endmodule : dcd_terminal
`default_nettype wire

// >>> testbench/dcd_top_test.sv
/*
  self-checking bench of dcd_top: apb master, framer stimulus, terminal.
  assumes dcd_pkg, monitor and terminal compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "dcd_defines.svh"
module dcd_top_test;
  import dcd_pkg::*;
  typedef struct {dcd_fmt_type f; logic [4:0] ch, ts; logic [7:0] b;}
    dcd_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
  logic fr_sync_lost, fr_bit_stb, fr_bit, fr_dl_req, dl_ins_bit, sent;
  logic dl_ins_stb, ser_tx_clk, ser_tx_data, ser_rx_clk, ser_rx_data;
  logic sync_loss_led, clip_led;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] fr_ts, fr_frame;
  logic [2:0] fr_bit_idx;
  logic [7:0] data_leds, tm_byte, tm_cnt, c;
  logic [3:0] chan_tens, chan_ones;
  logic [19:0] level_bar;
  dcd_fmt_type fmt_leds;
  int mismatches, checks_done, n;
  // format, channel, timeslot carrying it, byte
  dcd_row_type rows [7] = '{'{fmt_d3d4, 5'h18, 5'h18, 8'hA5},
    '{fmt_esf, 5'h05, 5'h05, 8'h3C}, '{fmt_d1d, 5'h0D, 5'h02, 8'h81},
    '{fmt_loop_carrier, 5'h0C, 5'h17, 8'h5A},
    '{fmt_d2, 5'h0C, 5'h01, 8'hC3}, '{fmt_d2, 5'h01, 5'h03, 8'h96},
    '{fmt_d2, 5'h14, 5'h16, 8'h69}};
  dcd_fmt_type dl_fmt [3] = '{fmt_esf, fmt_loop_carrier, fmt_d3d4};
  dcd_top #(.CLIP_HOLD_CYC(16)) i_dcd_top (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .fr_sync_lost, .fr_bit_stb, .fr_bit, .fr_ts, .fr_bit_idx, .fr_frame,
    .fr_dl_req, .dl_ins_bit, .dl_ins_stb, .ser_tx_clk, .ser_tx_data,
    .ser_rx_clk, .ser_rx_data, .data_leds, .sync_loss_led, .fmt_leds,
    .chan_tens, .chan_ones, .level_bar, .clip_led, .irq);
  dcd_terminal i_dcd_terminal (.presetn, .ser_tx_clk, .ser_tx_data,
    .ser_rx_clk, .ser_rx_data, .tm_byte, .tm_cnt, .sent);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic await(ref logic s, input int lim);
    for (int k = 0; s !== 1'b1; k++) begin
      @(posedge pclk);
      if (k == lim) begin
        chk("timeout", 1, 0);
        complete_run();
      end
    end
  endtask : await
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    await(pready, 8);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // strobes stay 9 cycles apart: the port needs an idle cycle after a pulse
  task automatic bit1(input logic [4:0] ts, input logic [2:0] i,
    input logic [4:0] fr, input logic b);
    @(posedge pclk);
    {fr_bit_stb, fr_ts, fr_bit_idx, fr_frame, fr_bit} <= {1'b1, ts, i, fr, b};
    @(posedge pclk);
    fr_bit_stb <= 1'b0;
    repeat (7) @(posedge pclk);
  endtask : bit1
  task automatic send_byte(input logic [4:0] ts, input logic [7:0] b);
    for (int i = 0; i < 8; i++) bit1(ts, 3'(i), 5'h01, b[7-i]);
  endtask : send_byte
  task automatic req();
    // the receive side only takes a request once back in idle
    repeat (2) @(posedge pclk);
    fr_dl_req <= 1'b1;
    @(posedge pclk);
    fr_dl_req <= 1'b0;
  endtask : req
  function automatic logic [31:0] ctl(dcd_fmt_type f, logic [4:0] ch,
    logic s);
    return {15'h0000, s, 3'h0, ch, 3'h0, f};
  endfunction : ctl
  initial begin
    {presetn, psel, penable, pwrite, fr_sync_lost, fr_bit_stb} = '0;
    {fr_bit, fr_dl_req, paddr, pwdata, fr_ts, fr_frame, fr_bit_idx} = '0;
    repeat (16) @(posedge pclk);
    chk("fmt", fmt_leds, fmt_d3d4);
    chk("chan", {chan_tens, chan_ones}, 8'h24);
    chk("clks", {ser_tx_clk, ser_rx_clk}, 2'h3);
    presetn <= 1'b1;
    apb(1'b0, `DCD_CTRL_OFS, 0);
    chk("ctrl", rd, 32'h00001804);
    foreach (rows[i]) begin
      apb(1'b1, `DCD_CTRL_OFS, ctl(rows[i].f, rows[i].ch, 1'b1));
      send_byte(rows[i].ts, rows[i].b);
      send_byte(5'h19 - rows[i].ts, ~rows[i].b);
      chk("leds", data_leds, rows[i].b);
      chk("drop", tm_byte, rows[i].b);
      chk("fmt", fmt_leds, rows[i].f);
      chk("chan", chan_tens * 10 + chan_ones, rows[i].ch);
    end
    foreach (dl_fmt[k]) begin
      apb(1'b1, `DCD_CTRL_OFS, ctl(dl_fmt[k], 5'h18, 1'b0));
      c = tm_cnt;
      for (int f = 1; f < 5; f++) bit1(5'h00, 3'h0, 5'(f), f > 2);
      chk("dl cnt", tm_cnt - c, k < 2 ? 2 : 0);
      if (k < 2) chk("dl bits", tm_byte[1:0], 2'h1);
    end
    apb(1'b1, `DCD_INT_CLR_OFS, 32'h7);
    apb(1'b1, `DCD_INT_EN_OFS, 32'h4);
    apb(1'b1, `DCD_CTRL_OFS, ctl(fmt_esf, 5'h03, 1'b1));
    repeat (4) begin
      req();
      await(dl_ins_stb, 12);
      chk("ins", dl_ins_bit, sent);
    end
    apb(1'b1, `DCD_CTRL_OFS, ctl(fmt_d3d4, 5'h18, 1'b1));
    req();
    n = 0;
    repeat (12) @(posedge pclk) n += int'(dl_ins_stb === 1'b1);
    chk("ins off", n, 0);
    apb(1'b0, `DCD_INT_STAT_OFS, 0);
    chk("ist", {rd[30:0], irq}, 32'h9);
    apb(1'b1, `DCD_INT_CLR_OFS, 32'h4);
    repeat (2) @(posedge pclk);
    chk("irq", irq, 1'b0);
    apb(1'b1, `DCD_INT_EN_OFS, 32'h2);
    fr_sync_lost <= 1'b1;
    send_byte(5'h18, 8'h3C);
    chk("blank", {data_leds, sync_loss_led}, 9'h001);
    apb(1'b0, `DCD_STAT_OFS, 0);
    chk("sync", rd[0], 1'b1);
    apb(1'b0, `DCD_INT_STAT_OFS, 0);
    chk("mask", {rd[0], irq}, 2'h2);
    fr_sync_lost <= 1'b0;
    apb(1'b1, `DCD_INT_CLR_OFS, 32'h1);
    repeat (4) send_byte(5'h18, 8'h01);
    chk("bar", {level_bar[0], clip_led}, 2'h2);
    send_byte(5'h18, 8'h80);
    chk("clip", {clip_led, level_bar[19], irq}, 3'h7);
    apb(1'b1, `DCD_INT_CLR_OFS, 32'h2);
    repeat (40) @(posedge pclk);
    chk("clip off", {clip_led, irq}, 2'h0);
    apb(1'b0, 12'h020, 0);
    chk("slverr", err, 1'b1);
    apb(1'b0, `DCD_INT_CLR_OFS, 0);
    chk("clr rd", rd, 0);
    apb(1'b1, `DCD_CTRL_OFS, ctl(fmt_d2, 5'h07, 1'b0));
    @(posedge pclk);
    chk("chan", {chan_tens, chan_ones}, 8'h07);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("fmt", fmt_leds, fmt_d3d4);
    chk("chan", {chan_tens, chan_ones}, 8'h24);
    presetn <= 1'b1;
    complete_run();
  end
endmodule : dcd_top_test
`default_nettype wire
